// ===== common/tms_pkg.sv
// shared constants, types and helpers for the table move and saturating arithmetic datapath
package tms_pkg;

   // datapath widths
   localparam int DATA_W = 16;   // word register width
   localparam int ADDR_W = 16;   // word register address width
   localparam int LEN_W = 16;    // table length field, wide enough to see bad lengths

   // allowed table length window, in words
   localparam logic [LEN_W-1:0] TBL_MIN = 16'h0001;
   localparam logic [LEN_W-1:0] TBL_MAX = 16'h0400;
   localparam logic [LEN_W-1:0] LEN_ONE = 16'h0001;  // last word still to go
   localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;  // cursor increment

   // signed 16-bit saturation limits
   localparam logic [DATA_W-1:0] SAT_HI = 16'h7fff;  // +32767
   localparam logic [DATA_W-1:0] SAT_LO = 16'h8000;  // -32768
   localparam logic signed [DATA_W:0] SAT_HI_X = 17'sh07fff;  // +32767, one bit wider
   localparam logic signed [DATA_W:0] SAT_LO_X = 17'sh18000;  // -32768, one bit wider

   // instruction selector
   typedef enum logic [2:0] {
      OP_FILL,
      OP_COPY,
      OP_INV,
      OP_ADD,
      OP_SUB
   } tms_op_e;

   // one instruction, as the sequencer presents it each scan
   typedef struct packed {
      tms_op_e op;                  // which instruction
      logic rung_in;                // instruction input condition
      logic [ADDR_W-1:0] src_addr;  // source table start
      logic [ADDR_W-1:0] dst_addr;  // destination start or result register
      logic [LEN_W-1:0] tbl_len;    // table size n
      logic [DATA_W-1:0] opa;       // fill value, augend or minuend
      logic [DATA_W-1:0] opb;       // addend or subtrahend
   } tms_req_s;

   // register memory read request
   typedef struct packed {
      logic re;
      logic [ADDR_W-1:0] addr;
   } tms_rd_s;

   // register memory write request
   typedef struct packed {
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } tms_wr_s;

   // true for the three table instructions
   function automatic logic is_table_op(input tms_op_e op);
      return (op == OP_FILL) || (op == OP_COPY) || (op == OP_INV);
   endfunction

   // table length inside the allowed window
   function automatic logic tbl_len_ok(input logic [LEN_W-1:0] len);
      return (len >= TBL_MIN) && (len <= TBL_MAX);
   endfunction

   // first address of a walk: base, or base plus n minus one when walking down
   function automatic logic [ADDR_W-1:0] tbl_start(input logic [ADDR_W-1:0] base,
                                                   input logic [LEN_W-1:0] len,
                                                   input logic down);
      logic [ADDR_W-1:0] top;
      top = base + len - ADDR_STEP;
      return down ? top : base;
   endfunction

endpackage

// ===== design/tms_addr_cursor.sv
// word address cursor that loads a start address and steps up or down
`timescale 1ns/10ps
module tms_addr_cursor
   import tms_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // control
   input wire logic load,
   input wire logic [ADDR_W-1:0] load_addr,
   input wire logic step,
   input wire logic down,
   // current address
   output logic [ADDR_W-1:0] addr
);

   logic [ADDR_W-1:0] addr_r;    // current word address
   logic [ADDR_W-1:0] addr_nxt;  // next word address

   // load wins over step; addresses wrap at the top of the space
   always_comb begin
      addr_nxt = addr_r;
      if (load) begin
         addr_nxt = load_addr;
      end else if (step) begin
         addr_nxt = down ? (addr_r - ADDR_STEP) : (addr_r + ADDR_STEP);
      end
   end

   // register only
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         addr_r <= '0;
      end else begin
         addr_r <= addr_nxt;
      end
   end

   assign addr = addr_r;

endmodule

// ===== design/tms_exec_top.sv
// execution datapath for table fill, table copy, inverted copy and saturating add/sub
// Behaviour
// - fill writes source value into n registers
// - table length accepted only from 1 to 1024
// - executed table instruction drives rung output on
// - copy moves n words source to destination
// - overlapping tables copy original source words
// - inverted copy stores complement of each word
// - add clamps to 32767 and -32768
// - arithmetic rung on only when result clamped
// - subtract second operand from first, store result
// - difference clamps to 32767 and -32768
`timescale 1ns/10ps
module tms_exec_top
   import tms_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // instruction from the sequencer
   input wire logic req_valid,
   input wire tms_req_s req,
   output logic req_ready,
   // register memory, one cycle read latency
   output tms_rd_s mem_rd,
   input wire logic [DATA_W-1:0] mem_rd_data,
   output tms_wr_s mem_wr,
   // completion
   output logic done,
   output logic rung_out,
   output logic len_err
);

   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,   // waiting for an instruction
      ST_FILL,   // one fill write per cycle
      ST_READ,   // issue a source read
      ST_WAIT,   // read in flight in the memory
      ST_WRITE,  // read data back, write destination
      ST_ARITH   // one saturated result write
   } tms_state_e;

   tms_state_e st_r;             // current state
   tms_state_e st_nxt;           // next state
   tms_req_s cur_r;              // instruction in progress
   tms_req_s cur_nxt;
   logic [LEN_W-1:0] remain_r;   // words still to write
   logic [LEN_W-1:0] remain_nxt;
   logic down_r;                 // walk tables from the top end
   logic down_nxt;
   tms_rd_s rd_r;                // registered read request
   tms_rd_s rd_nxt;
   tms_wr_s wr_r;                // registered write request
   tms_wr_s wr_nxt;
   logic done_r;                 // one-cycle completion pulse
   logic done_nxt;
   logic rung_r;                 // rung output of the last instruction
   logic rung_nxt;
   logic len_err_r;              // last instruction refused for its length
   logic len_err_nxt;

   logic accept;                 // instruction taken this cycle
   logic walk_down;              // direction chosen for the incoming copy
   logic src_step;               // advance the source cursor
   logic dst_step;               // advance the destination cursor
   logic [ADDR_W-1:0] src_addr;  // current source word
   logic [ADDR_W-1:0] dst_addr;  // current destination word
   logic [DATA_W-1:0] alu_res;   // clamped arithmetic result
   logic alu_clamp;              // arithmetic result was clamped

   // ready only when idle; no queue, the sequencer holds the request
   assign req_ready = (st_r == ST_IDLE);
   assign accept = req_valid && req_ready;

   // when the destination lies above the source, walk both tables downward so every
   // source word is read before an overlapping write can reach it
   assign walk_down = (req.op != OP_FILL) && (req.dst_addr > req.src_addr);

   // cursors advance after each destination write
   assign src_step = (st_r == ST_WRITE);
   assign dst_step = (st_r == ST_WRITE) || (st_r == ST_FILL);

   // source word cursor
   tms_addr_cursor u_src_cursor (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .load(accept),
      .load_addr(tbl_start(req.src_addr, req.tbl_len, walk_down)),
      .step(src_step),
      .down(down_r),
      .addr(src_addr)
   );

   // destination word cursor
   tms_addr_cursor u_dst_cursor (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .load(accept),
      .load_addr(tbl_start(req.dst_addr, req.tbl_len, walk_down)),
      .step(dst_step),
      .down(down_r),
      .addr(dst_addr)
   );

   // saturating adder works on the latched operands
   tms_sat_alu u_alu (
      .opa(cur_r.opa),
      .opb(cur_r.opb),
      .sub(cur_r.op == OP_SUB),
      .res(alu_res),
      .clamp(alu_clamp)
   );

   // next-state logic for the sequencer and its outputs
   always_comb begin
      st_nxt = st_r;
      cur_nxt = cur_r;
      remain_nxt = remain_r;
      down_nxt = down_r;
      rd_nxt = '0;
      wr_nxt = '0;
      done_nxt = 1'b0;
      rung_nxt = rung_r;
      len_err_nxt = len_err_r;
      case (st_r)
         ST_IDLE: begin
            // every presented instruction is evaluated afresh, no edge memory
            if (accept) begin
               cur_nxt = req;
               down_nxt = walk_down;
               remain_nxt = req.tbl_len;
               len_err_nxt = 1'b0;
               if (!req.rung_in) begin
                  // input off: nothing written, rung off at once
                  done_nxt = 1'b1;
                  rung_nxt = 1'b0;
               end else if (is_table_op(req.op) && !tbl_len_ok(req.tbl_len)) begin
                  // bad length: refuse, touch no register
                  done_nxt = 1'b1;
                  rung_nxt = 1'b0;
                  len_err_nxt = 1'b1;
               end else if (req.op == OP_FILL) begin
                  st_nxt = ST_FILL;
               end else if (is_table_op(req.op)) begin
                  st_nxt = ST_READ;
               end else begin
                  st_nxt = ST_ARITH;
               end
            end
         end
         ST_FILL: begin
            // same value into each consecutive destination word
            wr_nxt = '{we: 1'b1, addr: dst_addr, data: cur_r.opa};
            remain_nxt = remain_r - LEN_ONE;
            if (remain_r == LEN_ONE) begin
               st_nxt = ST_IDLE;
               done_nxt = 1'b1;
               rung_nxt = 1'b1;
            end
         end
         ST_READ: begin
            // fetch one source word
            rd_nxt = '{re: 1'b1, addr: src_addr};
            st_nxt = ST_WAIT;
         end
         ST_WAIT: begin
            // memory answers one cycle after it sees the read
            st_nxt = ST_WRITE;
         end
         ST_WRITE: begin
            // write the word read, complemented for the inverted copy
            wr_nxt.we = 1'b1;
            wr_nxt.addr = dst_addr;
            if (cur_r.op == OP_INV) begin
               wr_nxt.data = ~mem_rd_data;
            end else begin
               wr_nxt.data = mem_rd_data;
            end
            remain_nxt = remain_r - LEN_ONE;
            if (remain_r == LEN_ONE) begin
               st_nxt = ST_IDLE;
               done_nxt = 1'b1;
               rung_nxt = 1'b1;
            end else begin
               st_nxt = ST_READ;
            end
         end
         ST_ARITH: begin
            // result register always written; rung tells whether it clamped
            wr_nxt = '{we: 1'b1, addr: cur_r.dst_addr, data: alu_res};
            st_nxt = ST_IDLE;
            done_nxt = 1'b1;
            rung_nxt = alu_clamp;
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   // register only
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= ST_IDLE;
         cur_r <= '0;
         remain_r <= '0;
         down_r <= 1'b0;
         rd_r <= '0;
         wr_r <= '0;
         done_r <= 1'b0;
         rung_r <= 1'b0;
         len_err_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cur_r <= cur_nxt;
         remain_r <= remain_nxt;
         down_r <= down_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         done_r <= done_nxt;
         rung_r <= rung_nxt;
         len_err_r <= len_err_nxt;
      end
   end

   // outputs straight from flip-flops
   assign mem_rd = rd_r;
   assign mem_wr = wr_r;
   assign done = done_r;
   assign rung_out = rung_r;
   assign len_err = len_err_r;

   // helper: exact arithmetic results for the checks below
   logic signed [DATA_W:0] chk_sum;
   logic signed [DATA_W:0] chk_diff;
   assign chk_sum = {cur_r.opa[DATA_W-1], cur_r.opa} + {cur_r.opb[DATA_W-1], cur_r.opb};
   assign chk_diff = {cur_r.opa[DATA_W-1], cur_r.opa} - {cur_r.opb[DATA_W-1], cur_r.opb};
   logic [ADDR_W-1:0] chk_top;  // top word of the incoming source table
   assign chk_top = req.src_addr + req.tbl_len - ADDR_STEP;

   // each fill cycle writes the fill value at the destination cursor
   property p_fill_write;
      @(posedge clk_sys) disable iff (!reset_n)
      (st_r == ST_FILL) |=> (wr_r.we && wr_r.data == $past(cur_r.opa)
                             && wr_r.addr == $past(dst_addr));
   endproperty
   a_fill_write: assert property (p_fill_write) else $error("fill write wrong");

   // bad length on a live table instruction: refused next cycle, nothing written
   property p_len_refuse;
      @(posedge clk_sys) disable iff (!reset_n)
      (accept && req.rung_in && is_table_op(req.op) && !tbl_len_ok(req.tbl_len))
         |=> (done_r && len_err_r && !rung_r && !wr_r.we && st_r == ST_IDLE);
   endproperty
   a_len_refuse: assert property (p_len_refuse) else $error("bad length not refused");

   // a finished table instruction leaves the rung on
   property p_table_rung;
      @(posedge clk_sys) disable iff (!reset_n)
      (done_r && is_table_op(cur_r.op) && cur_r.rung_in && !len_err_r) |-> rung_r;
   endproperty
   a_table_rung: assert property (p_table_rung) else $error("table rung not on");

   // a one-word copy writes what was read, exactly four cycles after accept
   property p_copy_one;
      @(posedge clk_sys) disable iff (!reset_n)
      (accept && req.rung_in && req.op == OP_COPY && req.tbl_len == LEN_ONE)
         |=> ##1 rd_r.re ##2 (wr_r.we && wr_r.data == $past(mem_rd_data) && done_r);
   endproperty
   a_copy_one: assert property (p_copy_one) else $error("copy word wrong");

   // destination above source walks down from the top of both tables
   property p_overlap_down;
      @(posedge clk_sys) disable iff (!reset_n)
      (accept && req.rung_in && req.op == OP_COPY && tbl_len_ok(req.tbl_len)
       && req.dst_addr > req.src_addr)
         |=> (down_r && src_addr == $past(chk_top));
   endproperty
   a_overlap_down: assert property (p_overlap_down) else $error("overlap direction wrong");

   // inverted copy writes the complement of the word just read
   property p_inv_data;
      @(posedge clk_sys) disable iff (!reset_n)
      (st_r == ST_WRITE && cur_r.op == OP_INV) |=> (wr_r.data == ~$past(mem_rd_data));
   endproperty
   a_inv_data: assert property (p_inv_data) else $error("inverted data wrong");

   // add above the limit stores the upper limit with the rung on
   property p_add_clamp;
      @(posedge clk_sys) disable iff (!reset_n)
      (st_r == ST_ARITH && cur_r.op == OP_ADD && chk_sum > SAT_HI_X)
         |=> (wr_r.data == SAT_HI && rung_r && done_r);
   endproperty
   a_add_clamp: assert property (p_add_clamp) else $error("add not clamped");

   // in-range add leaves the rung off
   property p_arith_inrange;
      @(posedge clk_sys) disable iff (!reset_n)
      (st_r == ST_ARITH && cur_r.op == OP_ADD && chk_sum <= SAT_HI_X && chk_sum >= SAT_LO_X)
         |=> (!rung_r && wr_r.data == $past(chk_sum[DATA_W-1:0]));
   endproperty
   a_arith_inrange: assert property (p_arith_inrange) else $error("rung on in range");

   // in-range difference stored unchanged in the result register, rung off
   property p_sub_value;
      @(posedge clk_sys) disable iff (!reset_n)
      (st_r == ST_ARITH && cur_r.op == OP_SUB && chk_diff <= SAT_HI_X && chk_diff >= SAT_LO_X)
         |=> (wr_r.data == $past(chk_diff[DATA_W-1:0])
              && wr_r.addr == $past(cur_r.dst_addr) && !rung_r);
   endproperty
   a_sub_value: assert property (p_sub_value) else $error("difference wrong");

   // difference below the limit stores the lower limit with the rung on
   property p_sub_clamp;
      @(posedge clk_sys) disable iff (!reset_n)
      (st_r == ST_ARITH && cur_r.op == OP_SUB && chk_diff < SAT_LO_X)
         |=> (wr_r.data == SAT_LO && rung_r);
   endproperty
   a_sub_clamp: assert property (p_sub_clamp) else $error("sub not clamped");

   // input off: done next cycle, rung off, no write in the next two cycles
   property p_input_off;
      @(posedge clk_sys) disable iff (!reset_n)
      (accept && !req.rung_in) |=> (done_r && !rung_r && !wr_r.we) ##1 !wr_r.we;
   endproperty
   a_input_off: assert property (p_input_off) else $error("input off executed");

   // a request held while idle is taken on that same edge, every time
   property p_level_take;
      @(posedge clk_sys) disable iff (!reset_n)
      (st_r == ST_IDLE && req_valid) |=> (done_r || st_r != ST_IDLE);
   endproperty
   a_level_take: assert property (p_level_take) else $error("request not taken");

endmodule

// ===== design/tms_sat_alu.sv
// signed 16-bit add and subtract that clamp at the limits and flag the clamp
`timescale 1ns/10ps
module tms_sat_alu
   import tms_pkg::*;
(
   // operands
   input wire logic [DATA_W-1:0] opa,
   input wire logic [DATA_W-1:0] opb,
   input wire logic sub,
   // result
   output logic [DATA_W-1:0] res,
   output logic clamp
);

   logic signed [DATA_W:0] a_x;   // sign-extended first operand
   logic signed [DATA_W:0] b_x;   // sign-extended second operand
   logic signed [DATA_W:0] wide;  // exact result, cannot wrap in 17 bits

   // one spare bit keeps the true result so the limit test is exact
   always_comb begin
      a_x = {opa[DATA_W-1], opa};
      b_x = {opb[DATA_W-1], opb};
      wide = sub ? (a_x - b_x) : (a_x + b_x);
      if (wide > SAT_HI_X) begin
         // too large: pin at the upper limit
         res = SAT_HI;
         clamp = 1'b1;
      end else if (wide < SAT_LO_X) begin
         // too small: pin at the lower limit
         res = SAT_LO;
         clamp = 1'b1;
      end else begin
         // in range: plain result, no flag
         res = wide[DATA_W-1:0];
         clamp = 1'b0;
      end
   end

endmodule

// ===== sim/test_table_move_and_saturating_add_sub.sv
// self-checking bench for the table move and saturating add/sub datapath
`timescale 1ns/10ps
module test_table_move_and_saturating_add_sub;
   import tms_pkg::*;
   logic clk_sys, reset_n, req_valid, req_ready, done, rung_out, len_err;
   tms_req_s req;  // instruction presented by the bench in the sequencer's place
   tms_rd_s mem_rd;
   tms_wr_s mem_wr;
   logic [DATA_W-1:0] mem_rd_data;
   int n_mismatch, n_compared, n_cyc;
   logic got_rung, got_err;  // outputs captured in the done cycle

   tms_exec_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .mem_rd(mem_rd), .mem_rd_data(mem_rd_data), .mem_wr(mem_wr),
      .done(done), .rung_out(rung_out), .len_err(len_err));
   tms_mem_model mem_i (.clk_sys(clk_sys), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_rd_data(mem_rd_data));

   // 100 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // hang guard, far above the roughly 1300 cycles the run needs
   always @(posedge clk_sys) begin
      n_cyc <= n_cyc + 1;
      if (n_cyc == 30000) begin
         n_mismatch = n_mismatch + 1;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic cmp16(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // present one instruction until taken, then wait for done; entered just after an edge
   task automatic issue(input tms_op_e op, input logic on, input logic [15:0] src,
                        input logic [15:0] dst, input logic [15:0] len,
                        input logic [15:0] a, input logic [15:0] b);
      int k;
      req.op = op;
      req.rung_in = on;
      req.src_addr = src;
      req.dst_addr = dst;
      req.tbl_len = len;
      req.opa = a;
      req.opb = b;
      req_valid = 1'b1;
      k = 0;
      while (req_ready !== 1'b1 && k < 100) begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      @(posedge clk_sys);
      #1;
      req_valid = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 5000) begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      cmp1(done, 1'b1);
      got_rung = rung_out;
      got_err = len_err;
      // the last write leaves the datapath together with done and lands one edge later
      @(posedge clk_sys);
      #1;
   endtask

   // fill, boundary word untouched, then the same fill again after a poke
   task automatic t_fill();
      mem_i.mem[16'h0103] = 16'h1111;
      issue(OP_FILL, 1'b1, 16'h0000, 16'h0100, 16'h0003, 16'ha5a5, 16'h0000);
      cmp1(got_rung, 1'b1);
      for (int i = 0; i < 3; i++) cmp16(mem_i.mem[16'h0100 + i], 16'ha5a5);
      cmp16(mem_i.mem[16'h0103], 16'h1111);
      mem_i.mem[16'h0101] = 16'h0000;
      issue(OP_FILL, 1'b1, 16'h0000, 16'h0100, 16'h0003, 16'ha5a5, 16'h0000);
      cmp16(mem_i.mem[16'h0101], 16'ha5a5);
      issue(OP_FILL, 1'b1, 16'h0000, 16'h1000, 16'h0400, 16'h5a5a, 16'h0000);
      cmp1(got_err, 1'b0);
      cmp16(mem_i.mem[16'h13ff], 16'h5a5a);
      cmp16(mem_i.mem[16'h1400], 16'h1400 ^ 16'h3c5a);
   endtask

   // lengths outside 1..1024 on every table instruction: refused, nothing written
   task automatic t_len();
      tms_op_e ops [3] = '{OP_FILL, OP_COPY, OP_INV};
      logic [15:0] lens [3] = '{16'h0000, 16'h0401, 16'hffff};
      int w0;
      foreach (ops[i]) begin
         foreach (lens[j]) begin
            w0 = mem_i.n_wr;
            issue(ops[i], 1'b1, 16'h0200, 16'h0300, lens[j], 16'h0000, 16'h0000);
            cmp1(got_err, 1'b1);
            cmp1(got_rung, 1'b0);
            cmp16(16'(mem_i.n_wr - w0), 16'h0000);
         end
      end
   endtask

   // block copy or inverted copy, expectation from a snapshot taken before the run
   task automatic copy_chk(input tms_op_e op, input logic [15:0] src, input logic [15:0] dst,
                           input int n);
      logic [15:0] snap [$];
      for (int i = 0; i < n; i++) snap.push_back(mem_i.mem[16'(src + i)]);
      issue(op, 1'b1, src, dst, 16'(n), 16'h0000, 16'h0000);
      cmp1(got_rung, 1'b1);
      for (int i = 0; i < n; i++) begin
         if (op == OP_INV) cmp16(mem_i.mem[16'(dst + i)], ~snap[i]);
         else cmp16(mem_i.mem[16'(dst + i)], snap[i]);
      end
   endtask

   task automatic t_copy();
      logic [15:0] tbl [5] = '{16'h00ff, 16'h0000, 16'h1234, 16'h5555, 16'h89ab};
      foreach (tbl[i]) mem_i.mem[16'h0600 + i] = tbl[i];
      copy_chk(OP_COPY, 16'h0500, 16'h3000, 10);
      copy_chk(OP_COPY, 16'h0200, 16'h0203, 8);
      copy_chk(OP_COPY, 16'h0210, 16'h020e, 8);
      copy_chk(OP_COPY, 16'h0400, 16'h0401, 1);
      copy_chk(OP_INV, 16'h0600, 16'h0865, 5);
      copy_chk(OP_INV, 16'h0700, 16'h0702, 4);
      copy_chk(OP_INV, 16'h0720, 16'h071d, 6);
   endtask

   // add and subtract, plain and clamped at both limits
   task automatic t_arith();
      tms_op_e ops [9] = '{OP_ADD, OP_ADD, OP_ADD, OP_ADD, OP_SUB, OP_SUB, OP_SUB, OP_SUB,
                           OP_SUB};
      logic [15:0] a [9] = '{16'h3039, 16'h7fbc, 16'h8000, 16'h7fff, 16'h3a98, 16'h86e8,
                             16'h7fff, 16'h8000, 16'h0000};
      logic [15:0] b [9] = '{16'h03e8, 16'h03e8, 16'hffff, 16'h0000, 16'h09c4, 16'h09c4,
                             16'hffff, 16'h7fff, 16'h8000};
      logic [15:0] r [9] = '{16'h3421, 16'h7fff, 16'h8000, 16'h7fff, 16'h30d4, 16'h8000,
                             16'h7fff, 16'h8000, 16'h7fff};
      logic c [9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
      int w0;
      foreach (ops[i]) begin
         w0 = mem_i.n_wr;
         issue(ops[i], 1'b1, 16'h0000, 16'(16'h4000 + i), 16'h0000, a[i], b[i]);
         cmp16(mem_i.mem[16'(16'h4000 + i)], r[i]);
         cmp1(got_rung, c[i]);
         cmp16(16'(mem_i.n_wr - w0), 16'h0001);
      end
   endtask

   // input off on every instruction right after a rung-on one: no writes, rung off
   task automatic t_off();
      tms_op_e ops [5] = '{OP_FILL, OP_COPY, OP_INV, OP_ADD, OP_SUB};
      int w0;
      foreach (ops[i]) begin
         issue(OP_ADD, 1'b1, 16'h0000, 16'h4100, 16'h0000, 16'h7fff, 16'h0001);
         w0 = mem_i.n_wr;
         issue(ops[i], 1'b0, 16'h0200, 16'h0100, 16'h0000, 16'hffff, 16'h0001);
         cmp1(got_rung, 1'b0);
         cmp1(got_err, 1'b0);
         cmp16(16'(mem_i.n_wr - w0), 16'h0000);
      end
   endtask

   // reset, preload, scenarios back to back
   initial begin
      n_mismatch = 0;
      n_compared = 0;
      n_cyc = 0;
      reset_n = 1'b0;
      req_valid = 1'b0;
      req = '0;
      for (int i = 0; i < 65536; i++) mem_i.mem[i] = 16'(i) ^ 16'h3c5a;
      repeat (3) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      t_fill();
      t_len();
      t_copy();
      t_arith();
      t_off();
      report_and_stop();
   end
endmodule

// ===== sim/tms_mem_model.sv
// register memory model standing behind the datapath's read and write ports
`timescale 1ns/10ps
module tms_mem_model
   import tms_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // requests from the datapath
   input wire tms_rd_s mem_rd,
   input wire tms_wr_s mem_wr,
   // read answer
   output logic [DATA_W-1:0] mem_rd_data
);
   logic [DATA_W-1:0] mem [0:65535];  // whole 16-bit word space, loaded by the bench
   int n_wr;  // count of write pulses seen, lets the bench prove no-write cases

   initial begin
      mem_rd_data = 16'h0000;
      n_wr = 0;
   end

   // plain always, not always_ff: the bench preloads words through hierarchy while idle
   always @(posedge clk_sys) begin
      if (mem_wr.we) begin
         mem[mem_wr.addr] <= mem_wr.data;
         n_wr <= n_wr + 1;
      end
      // answer exactly one cycle later; otherwise toggle so stale data never looks valid
      if (mem_rd.re) begin
         mem_rd_data <= mem[mem_rd.addr];
      end else begin
         mem_rd_data <= ~mem_rd_data;
      end
   end
endmodule
